// file: logic/spi_consts.svh
// named constants for the spi transfer engine
// assumes inclusion by its bare name from the core
`ifndef SPI_CONSTS_SVH
`define SPI_CONSTS_SVH
`define SPI_BYTE_BITS 4'h8
`define SPI_LAST_HALF 4'hF
`define SPI_HALF_DIV4 7'h02
`define SPI_HALF_DIV16 7'h08
`define SPI_HALF_DIV64 7'h20
`define SPI_HALF_DIV128 7'h40
`define SPI_HALF_ONE 7'h01
`define SPI_DATA_RST 8'h00
`define SPI_CNT_RST 4'h0
`define SPI_HALF_RST 7'h00
`endif

// file: logic/spi_pkg.sv
// types shared by the spi transfer engine and its bench
// assumes spi_consts.svh holds the numeric constants
package spi_pkg;
  // static configuration, set up before enable goes high
  typedef struct packed {
    logic [1:0] clock_divider_select;
    logic rate_doubling_bit;
    logic [1:0] mode;
    logic bit_order_bit;
    logic buffering_on_bit;
    logic wait_for_receive_bit;
    logic select_pin_ignore_bit;
  } cfg_t;
  // port direction bits, 1 = configured as output
  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
    logic ss;
  } pin_dir_t;
  // master sequencer
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } state_t;
endpackage

// file: logic/spi_core.sv
// spi master/slave transfer engine with an 8-bit shift register
// assumes all inputs are synchronous to core_clk_i except sck_i
// Operation
// - one 8-bit register shifts out and in
// - write loads shifter, or transmit buffer when buffered
// - read gives first buffer, or fifo when buffered
// - master makes sck, slave samples synchronized sck
// - enabled: force pin directions per role
// - output pins carry values from spi logic
// - slave miso driven only while select low
// - master write starts eight-bit transfer
// - master sets done flag after byte
// - select low starts; mosi in, miso out
// - ignore bit set: master ignores select pin
// - select configured output does not affect spi
// - select input low means rival master
// - rival master: drop role, become slave
// - rival master also sets done flag
// - seven sck rates incl. clock divided two
// - bit order bit picks lsb or msb
// - debug halt freezes the engine
// - unbuffered busy write sets collision flag
// - slave select high resets transfer at once
// - buffered: accept writes while space flag set
`timescale 1ns/10ps
`include "spi_consts.svh"

module spi_core #(
  parameter int RX_DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // configuration
  input wire logic enable_i,
  input wire spi_pkg::cfg_t cfg_i,
  input wire spi_pkg::pin_dir_t dir_i,
  input wire logic role_wr_i,
  input wire logic role_wdata_i,
  input wire logic debug_halt_i,
  // status flags
  output logic is_master_o,
  output logic done_flag_o,
  input wire logic done_clr_i,
  output logic write_collision_flag_o,
  input wire logic wcol_clr_i,
  output logic transmit_space_flag_o,
  // transmit data
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  // receive data
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  input wire logic rd_ready_i,
  // pins, oe_n low while driving
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  input wire logic ss_i,
  output logic ss_o,
  output logic ss_oe_n_o
);

  localparam int AW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

  // half period of sck in core clocks
  function automatic logic [6:0] half_period(input logic [1:0] sel, input logic dbl);
    logic [6:0] base;
    case (sel)
      2'h0: base = `SPI_HALF_DIV4;
      2'h1: base = `SPI_HALF_DIV16;
      2'h2: base = `SPI_HALF_DIV64;
      default: base = `SPI_HALF_DIV128;
    endcase
    half_period = dbl ? (base >> 1) : base;
  endfunction

  // shift one received bit in, dropping the bit already sent
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b, input logic lsb);
    shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  // bit that leaves the shifter next
  function automatic logic out_bit(input logic [7:0] sr, input logic lsb);
    out_bit = lsb ? sr[0] : sr[7];
  endfunction

  // state registers
  logic role, next_role;
  spi_pkg::state_t st, next_st;
  logic [7:0] sr, next_sr;
  logic dout, next_dout;
  logic sck_q, next_sck_q;
  logic [6:0] half_cnt, next_half_cnt;
  logic [3:0] edge_cnt, next_edge_cnt;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] txbuf, next_txbuf;
  logic txbuf_full, next_txbuf_full;
  logic done, next_done;
  logic wcol, next_wcol;
  logic [7:0] last_rx, next_last_rx;
  logic rx_full, next_rx_full;
  logic [7:0] mem [RX_DEPTH];
  logic [7:0] next_mem [RX_DEPTH];
  logic [AW-1:0] wp, next_wp, rp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic sck_s1, sck_s2, sck_s3;

  // decoded configuration
  logic cpol, cpha, lsb, buf_on, fifo_full, busy, slave_on;
  logic [6:0] half_lim;
  assign cpol = cfg_i.mode[1];
  assign cpha = cfg_i.mode[0];
  assign lsb = cfg_i.bit_order_bit;
  assign buf_on = cfg_i.buffering_on_bit;
  assign half_lim = half_period(cfg_i.clock_divider_select, cfg_i.rate_doubling_bit);
  assign fifo_full = (cnt == (AW+1)'(RX_DEPTH));
  assign slave_on = enable_i && !role;
  assign busy = role ? (st == spi_pkg::ST_SHIFT) : (bit_cnt != `SPI_CNT_RST);

  // sck synchronizer; edges look only at the second and third stage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
    end else begin
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end

  // handshake and status outputs
  assign wr_ready_o = buf_on ? !txbuf_full : !busy;
  assign transmit_space_flag_o = enable_i && wr_ready_o;
  assign rd_valid_o = buf_on ? (cnt != '0) : rx_full;
  assign rd_data_o = buf_on ? mem[rp] : last_rx;
  assign is_master_o = role;
  assign done_flag_o = done;
  assign write_collision_flag_o = wcol;
  assign mosi_o = dout;
  assign miso_o = dout;
  assign sck_o = sck_q;
  assign ss_o = 1'b1;

  // pin direction override; port direction rules when disabled
  always_comb begin
    mosi_oe_n_o = !dir_i.mosi;
    miso_oe_n_o = !dir_i.miso;
    sck_oe_n_o = !dir_i.sck;
    ss_oe_n_o = !dir_i.ss;
    if (enable_i && role) begin
      miso_oe_n_o = 1'b1;
    end else if (enable_i) begin
      mosi_oe_n_o = 1'b1;
      sck_oe_n_o = 1'b1;
      ss_oe_n_o = 1'b1;
      miso_oe_n_o = !(dir_i.miso && !ss_i);
    end
  end

  // next-state logic of the whole engine
  always_comb begin
    logic push, done_set, wcol_set, lead, samp, rise, fall, loss;
    logic [7:0] push_data;
    push = 1'b0;
    done_set = 1'b0;
    wcol_set = 1'b0;
    lead = 1'b0;
    samp = 1'b0;
    rise = sck_s2 && !sck_s3;
    fall = !sck_s2 && sck_s3;
    loss = 1'b0;
    push_data = sr;
    next_role = role;
    next_st = st;
    next_sr = sr;
    next_dout = dout;
    next_sck_q = sck_q;
    next_half_cnt = half_cnt;
    next_edge_cnt = edge_cnt;
    next_bit_cnt = bit_cnt;
    next_txbuf = txbuf;
    next_txbuf_full = txbuf_full;
    next_done = done;
    next_wcol = wcol;
    next_last_rx = last_rx;
    next_rx_full = rx_full;
    next_mem = mem;
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    // a halted cpu freezes everything
    if (!debug_halt_i) begin
      if (role_wr_i) begin
        next_role = role_wdata_i;
      end
      // rival master pulls select low; select as output is ignored
      loss = enable_i && role && !cfg_i.select_pin_ignore_bit
        && !dir_i.ss && !ss_i;
      if (!enable_i) begin
        // disabled engine idles with sck at cpol, bit count cleared and transmit buffer emptied
        next_st = spi_pkg::ST_IDLE;
        next_sck_q = cpol;
        next_bit_cnt = `SPI_CNT_RST;
        next_txbuf_full = 1'b0;
      end else if (loss) begin
        next_role = 1'b0;
        next_st = spi_pkg::ST_IDLE;
        next_sck_q = cpol;
        next_bit_cnt = `SPI_CNT_RST;
        done_set = 1'b1;
      end else begin
        // software write of the data register
        if (wr_valid_i) begin
          if (!wr_ready_o) begin
            // dropped word; only unbuffered mode flags it
            wcol_set = !buf_on;
          end else if (buf_on) begin
            next_txbuf = wr_data_i;
            next_txbuf_full = 1'b1;
          end else begin
            next_sr = wr_data_i;
            next_dout = out_bit(wr_data_i, lsb);
            if (role) begin
              next_st = spi_pkg::ST_SHIFT;
              next_half_cnt = `SPI_HALF_RST;
              next_edge_cnt = `SPI_CNT_RST;
            end
          end
        end
        if (role) begin
          if (st == spi_pkg::ST_IDLE) begin
            next_sck_q = cpol;
            // full receive fifo holds off the next byte
            if (buf_on && txbuf_full && !fifo_full) begin
              next_sr = txbuf;
              next_dout = out_bit(txbuf, lsb);
              next_txbuf_full = 1'b0;
              next_st = spi_pkg::ST_SHIFT;
              next_half_cnt = `SPI_HALF_RST;
              next_edge_cnt = `SPI_CNT_RST;
            end
          end else if (half_cnt == half_lim - `SPI_HALF_ONE) begin
            next_half_cnt = `SPI_HALF_RST;
            next_sck_q = !sck_q;
            lead = !edge_cnt[0];
            if (lead ^ cpha) begin
              next_sr = shift_in(sr, miso_i, lsb);
            end else begin
              next_dout = out_bit(sr, lsb);
            end
            next_edge_cnt = edge_cnt + 4'h1;
            if (edge_cnt == `SPI_LAST_HALF) begin
              next_st = spi_pkg::ST_IDLE;
              push = 1'b1;
              push_data = next_sr;
              done_set = 1'b1;
            end
          end else begin
            next_half_cnt = half_cnt + `SPI_HALF_ONE;
          end
        end else if (ss_i) begin
          // deselected slave drops the byte in progress
          next_bit_cnt = `SPI_CNT_RST;
          if (buf_on && txbuf_full) begin
            next_sr = txbuf;
            next_txbuf_full = 1'b0;
          end
          next_dout = out_bit(next_sr, lsb);
        end else begin
          lead = cpol ? fall : rise;
          samp = cpha ? (cpol ? rise : fall) : lead;
          if (samp) begin
            next_sr = shift_in(sr, mosi_i, lsb);
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == `SPI_BYTE_BITS - 4'h1) begin
              next_bit_cnt = `SPI_CNT_RST;
              push = 1'b1;
              push_data = next_sr;
              done_set = 1'b1;
              if (buf_on && txbuf_full) begin
                next_sr = txbuf;
                next_txbuf_full = 1'b0;
              end
            end
          end else if (rise || fall) begin
            next_dout = out_bit(sr, lsb);
          end
        end
      end
      // receive buffers; a read pops the oldest word
      if (rd_ready_i && rd_valid_o) begin
        if (buf_on) begin
          next_rp = (rp == AW'(RX_DEPTH - 1)) ? '0 : rp + AW'(1);
          next_cnt = next_cnt - (AW+1)'(1);
        end else begin
          next_rx_full = 1'b0;
        end
      end
      if (push) begin
        next_last_rx = push_data;
        next_rx_full = 1'b1;
        // a slave cannot stall the master: overflow drops the word
        if (buf_on && (next_cnt != (AW+1)'(RX_DEPTH))) begin
          next_mem[wp] = push_data;
          next_wp = (wp == AW'(RX_DEPTH - 1)) ? '0 : wp + AW'(1);
          next_cnt = next_cnt + (AW+1)'(1);
        end
      end
      // hardware set wins over a clear in the same cycle
      next_done = (done && !done_clr_i) || done_set;
      next_wcol = (wcol && !wcol_clr_i) || wcol_set;
    end
  end

  // register stage of the engine
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      role <= 1'b0;
      st <= spi_pkg::ST_IDLE;
      sr <= `SPI_DATA_RST;
      dout <= 1'b0;
      sck_q <= 1'b0;
      half_cnt <= `SPI_HALF_RST;
      edge_cnt <= `SPI_CNT_RST;
      bit_cnt <= `SPI_CNT_RST;
      txbuf <= `SPI_DATA_RST;
      txbuf_full <= 1'b0;
      done <= 1'b0;
      wcol <= 1'b0;
      last_rx <= `SPI_DATA_RST;
      rx_full <= 1'b0;
      for (int i = 0; i < RX_DEPTH; i++) begin
        mem[i] <= `SPI_DATA_RST;
      end
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      role <= next_role;
      st <= next_st;
      sr <= next_sr;
      dout <= next_dout;
      sck_q <= next_sck_q;
      half_cnt <= next_half_cnt;
      edge_cnt <= next_edge_cnt;
      bit_cnt <= next_bit_cnt;
      txbuf <= next_txbuf;
      txbuf_full <= next_txbuf_full;
      done <= next_done;
      wcol <= next_wcol;
      last_rx <= next_last_rx;
      rx_full <= next_rx_full;
      mem <= next_mem;
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

endmodule

// file: verif/spi_core_chk.sv
// port assertions for the spi engine
// assumes it is bound into spi_core and sees one clock domain
`timescale 1ns/10ps
module spi_core_chk (
  // clock, reset and controls
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire spi_pkg::cfg_t cfg_i,
  input wire spi_pkg::pin_dir_t dir_i,
  input wire logic role_wr_i,
  input wire logic debug_halt_i,
  input wire logic wr_valid_i,
  input wire logic ss_i,
  // watched outputs
  input wire logic is_master_o,
  input wire logic done_flag_o,
  input wire logic write_collision_flag_o,
  input wire logic wr_ready_o,
  input wire logic mosi_o,
  input wire logic mosi_oe_n_o,
  input wire logic miso_oe_n_o,
  input wire logic sck_o,
  input wire logic sck_oe_n_o,
  input wire logic ss_oe_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // rival master pulls an input select low
  wire loss = enable_i && is_master_o && !cfg_i.select_pin_ignore_bit && !dir_i.ss && !ss_i;
  // an unbuffered master write the engine would consider
  wire wr_ok = enable_i && !debug_halt_i && !loss && wr_valid_i && is_master_o &&
    !cfg_i.buffering_on_bit;
  busy_start_a: assert property (wr_ok && wr_ready_o |=> !wr_ready_o)
    else $error("taken write did not make the engine busy");
  wcol_set_a: assert property (wr_ok && !wr_ready_o |=> write_collision_flag_o)
    else $error("busy write did not flag a collision");
  loss_a: assert property (loss && !debug_halt_i |=>
    !is_master_o && done_flag_o)
    else $error("low select did not drop the master role");
  role_keep_a: assert property (enable_i && is_master_o && !role_wr_i &&
    !debug_halt_i && (cfg_i.select_pin_ignore_bit || dir_i.ss) |=> is_master_o)
    else $error("master role lost while select is ignored");
  miso_gate_a: assert property (enable_i && !is_master_o && dir_i.miso |->
    miso_oe_n_o == ss_i)
    else $error("slave miso buffer not following select");
  master_dir_a: assert property (enable_i && is_master_o |-> miso_oe_n_o)
    else $error("master drives miso");
  slave_dir_a: assert property (enable_i && !is_master_o |->
    mosi_oe_n_o && sck_oe_n_o && ss_oe_n_o)
    else $error("slave drives an input pin");
  drive_out_a: assert property (enable_i && is_master_o && dir_i.mosi |-> !mosi_oe_n_o)
    else $error("master leaves an output mosi undriven");
  halt_freeze_a: assert property (debug_halt_i |=> $stable(sck_o) && $stable(mosi_o))
    else $error("engine moved during debug halt");
  // main scenarios reached
  cover property (loss);
  cover property (wr_ok && !wr_ready_o);
  cover property (enable_i && !is_master_o && !ss_i);
endmodule

// file: verif/spi_slave_model.sv
// behavioural spi slave on the far side of the engine
// assumes the bench selects it with cs_n and sets mode and order
`timescale 1ns/10ps
module spi_slave_model (
  // bus side
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // settings and data
  input wire logic [1:0] mode,
  input wire logic lsb,
  input wire logic [7:0] reply,
  output logic [7:0] got
);
  logic [7:0] tx;
  int k;
  function automatic logic pick(int i);
    return lsb ? tx[i] : tx[7 - i];
  endfunction
  initial begin
    miso = 1'h0;
    got = 8'h00;
  end
  // select low loads reply; phase 0 shows its first bit at once
  always @(negedge cs_n) begin
    tx = reply;
    k = mode[0] ? 0 : 1;
    if (!mode[0]) miso = pick(0);
  end
  // a released line shows the inverse so a stale value cannot pass
  always @(posedge cs_n) miso = ~miso;
  // sample edge shifts in, the other edge moves out; reload between bytes
  always @(sck) begin
    if (!cs_n) begin
      if (sck == (mode[1] == mode[0])) got = lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
      else begin
        if (k == 8) begin
          tx = reply;
          k = 0;
        end
        miso = pick(k);
        k++;
      end
    end
  end
endmodule

// file: verif/spi_core_tb_top.sv
// self-checking bench for the spi engine with a slave model on its bus
// assumes spi_pkg, spi_core, the checker and the model compiled first
`timescale 1ns/10ps
module spi_core_tb_top;
  logic core_clk_i, rst_n_i, enable_i, role_wr_i, role_wdata_i, debug_halt_i, done_clr_i;
  logic wcol_clr_i, wr_valid_i, rd_ready_i, mosi_i, miso_i, sck_i, ss_i, cs_n, plsb;
  logic is_master_o, done_flag_o, write_collision_flag_o, transmit_space_flag_o, wr_ready_o;
  logic rd_valid_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, sck_o, sck_oe_n_o, ss_o, ss_oe_n_o;
  logic [7:0] wr_data_i, rd_data_o, reply, pgot;
  logic [1:0] pmode;
  spi_pkg::cfg_t cfg_i;
  spi_pkg::pin_dir_t dir_i;
  int err_count = 0;
  int n_compared = 0;
  int hv[4] = '{2, 8, 32, 64};
  spi_core #(.RX_DEPTH(2)) uut (.core_clk_i, .rst_n_i, .enable_i, .cfg_i, .dir_i, .role_wr_i,
    .role_wdata_i, .debug_halt_i, .is_master_o, .done_flag_o, .done_clr_i,
    .write_collision_flag_o, .wcol_clr_i, .transmit_space_flag_o, .wr_valid_i, .wr_data_i,
    .wr_ready_o, .rd_valid_o, .rd_data_o, .rd_ready_i, .mosi_i, .mosi_o, .mosi_oe_n_o, .miso_i,
    .miso_o, .miso_oe_n_o, .sck_i, .sck_o, .sck_oe_n_o, .ss_i, .ss_o, .ss_oe_n_o);
  spi_slave_model peer (.sck(sck_o), .cs_n, .mosi(mosi_o), .miso(miso_i), .mode(pmode),
    .lsb(plsb), .reply, .got(pgot));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // inputs always change 1 ns after the rising edge
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic pulse_clr;
    done_clr_i = 1'h1;
    wcol_clr_i = 1'h1;
    rd_ready_i = 1'h1;
    tick();
    done_clr_i = 1'h0;
    wcol_clr_i = 1'h0;
    rd_ready_i = 1'h0;
  endtask
  task automatic wait_done(int lim);
    for (int n = 0; done_flag_o !== 1'h1; n++) begin
      if (n > lim) begin
        check("done wait", 16'h0000, 16'h0001);
        report_and_stop();
      end
      tick();
    end
  endtask
  // role and settings go in with the engine off; enable comes last
  task automatic setup(input logic [8:0] c, input logic [3:0] d, input logic m);
    enable_i = 1'h0;
    cfg_i = c;
    dir_i = d;
    role_wr_i = 1'h1;
    role_wdata_i = m;
    tick();
    role_wr_i = 1'h0;
    enable_i = 1'h1;
    tick();
  endtask
  task automatic put(input logic [7:0] b);
    wr_data_i = b;
    wr_valid_i = 1'h1;
    tick();
    wr_valid_i = 1'h0;
  endtask
  // every rate, mode and order; a write lands mid-byte and must be refused
  task automatic t_rates;
    for (int j = 0; j < 8; j++) begin
      logic [2:0] i;
      int n;
      i = 3'(j);
      pmode = i[1:0];
      plsb = i[2];
      reply = 8'h5A ^ {5'h00, i};
      setup({i[1:0], i[2], i[1:0], i[2], 3'h0}, 4'hB, 1'h1); // ss held high by us
      check("mosi drive", mosi_oe_n_o, 1'h0);
      pulse_clr();
      cs_n = 1'h0;
      put(8'hC0 + 8'(j));
      for (n = 0; done_flag_o !== 1'h1 && n < 1100; n++) begin
        // the strobe was just released by put, so leave it alone this step
        if (n > 0) wr_valid_i = (n == 2);
        wr_data_i = 8'hFF;
        tick();
      end
      wr_valid_i = 1'h0;
      check("cycles", 16'(n), 16'(16 * (hv[i[1:0]] >> i[2])));
      check("rx byte", rd_data_o, reply);
      check("peer got", pgot, 8'hC0 + 8'(j));
      check("collision", write_collision_flag_o, 1'h1);
      cs_n = 1'h1;
      pulse_clr();
    end
  endtask
  // two queued bytes with the reader stalled and a debug halt, then drain
  task automatic t_buffered;
    pmode = 2'h0;
    plsb = 1'h0;
    reply = 8'h3C;
    setup(9'h104, 4'hB, 1'h1);
    cs_n = 1'h0;
    put(8'h11);
    // the buffer hands the first byte to the shifter one cycle later
    tick();
    check("ready", wr_ready_o, 1'h1);
    put(8'h22);
    check("space", transmit_space_flag_o, 1'h0);
    debug_halt_i = 1'h1;
    tick(6);
    debug_halt_i = 1'h0;
    wait_done(600);
    done_clr_i = 1'h1;
    tick();
    done_clr_i = 1'h0;
    wait_done(600);
    // reader held ready across both pops, one word per edge
    for (int p = 0; p < 2; p++) begin
      check("fifo data", {rd_valid_o, rd_data_o}, 9'h13C);
      rd_ready_i = 1'h1;
      tick();
    end
    rd_ready_i = 1'h0;
    check("fifo empty", rd_valid_o, 1'h0);
    check("peer got", pgot, 8'h22);
    cs_n = 1'h1;
  endtask
  // nb slave bits, msb first, in mode 0: data set while sck low, captured at rise
  task automatic sbyte(input logic [7:0] d, input int nb, output logic [7:0] q);
    for (int b = 7; b > 7 - nb; b--) begin
      mosi_i = d[b];
      tick(4);
      q[b] = miso_o;
      sck_i = 1'h1;
      tick(4);
      sck_i = 1'h0;
    end
    tick(4);
  endtask
  // slave: miso gated by select; a mid-byte deselect restarts the count
  task automatic t_slave;
    logic [7:0] q;
    ss_i = 1'h1;
    setup(9'h000, 4'h4, 1'h0);
    put(8'hC3);
    check("miso off", miso_oe_n_o, 1'h1);
    ss_i = 1'h0;
    tick();
    check("miso on", {miso_oe_n_o, sck_oe_n_o, mosi_oe_n_o}, 3'h3);
    sbyte(8'h6B, 8, q);
    check("slave tx", q, 8'hC3);
    check("slave rx", rd_data_o, 8'h6B);
    pulse_clr();
    sbyte(8'hFF, 3, q);
    ss_i = 1'h1;
    tick(2);
    ss_i = 1'h0;
    tick();
    sbyte(8'h9D, 8, q);
    check("after abort", rd_data_o, 8'h9D);
    ss_i = 1'h1;
  endtask
  // select-pin handling of a master
  task automatic t_loss;
    pulse_clr();
    ss_i = 1'h0;
    setup(9'h101, 4'hA, 1'h1);
    tick(3);
    check("keep ignore", is_master_o, 1'h1);
    setup(9'h100, 4'hB, 1'h1);
    tick(3);
    check("keep output", is_master_o, 1'h1);
    setup(9'h100, 4'hA, 1'h1);
    check("lost", {is_master_o, done_flag_o, sck_oe_n_o}, 3'h3);
    ss_i = 1'h1;
  endtask
  initial begin
    core_clk_i = 1'h0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    {rst_n_i, enable_i, role_wr_i, role_wdata_i, debug_halt_i, done_clr_i} = 6'h00;
    {wcol_clr_i, wr_valid_i, rd_ready_i, mosi_i, sck_i, plsb, pmode} = 8'h00;
    {ss_i, cs_n, cfg_i, dir_i, wr_data_i, reply} = 31'h60000000;
    tick(3);
    rst_n_i = 1'h1;
    t_rates();
    t_buffered();
    t_slave();
    t_loss();
    report_and_stop();
  end
endmodule
bind spi_core spi_core_chk chk (.core_clk_i, .rst_n_i, .enable_i, .cfg_i, .dir_i, .role_wr_i,
  .debug_halt_i, .wr_valid_i, .ss_i, .is_master_o, .done_flag_o, .write_collision_flag_o,
  .wr_ready_o, .mosi_o, .mosi_oe_n_o, .miso_oe_n_o, .sck_o, .sck_oe_n_o, .ss_oe_n_o);
